//--- rtl/ubc_core.sv
// ubc_core: usb enable, pads, pll bring-up, event flags and endpoint-0 control transfers
`default_nettype none
module ubc_core import ubc_pkg::*; (
	input  wire logic          ref_clk,
	input  wire logic          rst,
	input  wire ubc_bus_req_t  bus_i,
	output logic [7:0]         bus_rdata,
	input  wire ubc_link_in_t  lnk_i,
	output ubc_link_out_t      lnk_o,
	output logic               usb_irq
);
	logic        usb_en_r, pullup_r, pll_en_r, pad_pd_r, usb_off_r, addressed_r;
	logic        lock_m_r, lock_s_r;
	logic [6:0]  faddr_r;
	logic [3:0]  epsel_r;
	logic        port2_cpu_irq_enable_r, port2_cpu_irq_flag_r, dplus_resume_flag_r, dplus_resume_irq_enable_r;
	logic        susp_d_r, dp_d_r;
	logic [7:0]  rdata_r, rdata_nxt;
	logic [7:0]  flg_r [3];
	logic [7:0]  msk_r [3];
	logic [7:0]  evt_v [3];
	logic [2:0]  hit;
	ubc_ep0_st_t ep0_st_r;
	logic        rx_wait_r, tx_load_r, sent_stall_r, data_end_r, setup_end_r, send_stall_r;
	logic        stat_r, stat_in_r, has_data_r, dir_in_r, pend_data_r, pend_stat_r;
	logic [6:0]  cnt_r;
	logic        ep0_evt_r, hs_v_r;
	logic [1:0]  hs_code_r;
	logic        srst, wr, rd, cs_wr, tok_me, stall_cond, dplus_resume_flag_set;
	logic        st_out_stat, st_in_stat, tx_data, rx_data;
	logic [3:0]  a;
	logic [7:0]  wd;

	assign wr    = bus_i.wr;
	assign rd    = bus_i.rd;
	assign a     = bus_i.addr;
	assign wd    = bus_i.wdata;
	assign srst  = ~usb_en_r;
	assign cs_wr = wr && (a == REG_EP0_CS) && (epsel_r == 4'h0);

	assign lnk_o = '{hs_v_r, hs_code_r, pullup_r, pad_pd_r, pll_en_r, usb_off_r, addressed_r};
	assign bus_rdata = rdata_r;

	// control and pad bits live outside the controller reset
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			usb_en_r <= 1'b0;
			usb_off_r <= 1'b1;
			pullup_r <= 1'b0;
			pll_en_r <= 1'b0;
			pad_pd_r <= 1'b0;
		end else begin
			if (wr && a == REG_CTRL) begin
				usb_en_r <= wd[B_USB_EN];
				usb_off_r <= !wd[B_USB_EN];
				pullup_r <= wd[B_PULLUP];
				pll_en_r <= wd[B_PLL_EN];
			end
			if (wr && a == REG_PAD)
				pad_pd_r <= wd[0];
		end
	end

	// lock comes from the pll's own clock, so it gets two flops
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lock_m_r <= 1'b0;
			lock_s_r <= 1'b0;
			addressed_r <= 1'b0;
		end else begin
			lock_m_r <= lnk_i.pll_lock;
			lock_s_r <= lock_m_r;
			addressed_r <= faddr_r != 7'h00;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			faddr_r <= 7'h00;
			epsel_r <= 4'h0;
		end else if (srst || lnk_i.bus_reset) begin
			faddr_r <= 7'h00;
			epsel_r <= 4'h0;
		end else begin
			if (wr && a == REG_FADDR)
				faddr_r <= wd[6:0];
			if (wr && a == REG_EPSEL)
				epsel_r <= wd[3:0];
		end
	end

	// line edges for suspend/resume and d+ wake detection
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			susp_d_r <= 1'b0;
			dp_d_r   <= 1'b1;
		end else begin
			susp_d_r <= lnk_i.suspended;
			dp_d_r   <= lnk_i.dplus;
		end
	end
	assign dplus_resume_flag_set = lnk_i.suspended && dp_d_r && !lnk_i.dplus;

	assign evt_v[0] = {4'h0, lnk_i.sof, lnk_i.bus_reset, susp_d_r && !lnk_i.suspended,
		!susp_d_r && lnk_i.suspended};
	assign evt_v[1] = {7'h00, ep0_evt_r};
	assign evt_v[2] = 8'h00;

	// three flag groups: clear on read, a same-cycle event survives the clear
	for (genvar g = 0; g < 3; g++) begin : g_flags
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				flg_r[g] <= 8'h00;
				msk_r[g] <= (g == 0) ? RST_CMSK : ((g == 1) ? RST_IMSK : RST_OMSK);
			end else if (srst) begin
				flg_r[g] <= 8'h00;
				msk_r[g] <= (g == 0) ? RST_CMSK : ((g == 1) ? RST_IMSK : RST_OMSK);
			end else begin
				if (wr && a == REG_MSK0 + 4'(g))
					msk_r[g] <= wd;
				flg_r[g] <= ((rd && a == REG_FLG0 + 4'(g)) ? 8'h00 : flg_r[g]) | evt_v[g];
			end
		end
		assign hit[g] = |(evt_v[g] & msk_r[g]);
	end

	// port-2 side: cpu flag, enable and the d+ resume flag
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			port2_cpu_irq_enable_r  <= 1'b0;
			port2_cpu_irq_flag_r  <= 1'b0;
			dplus_resume_flag_r  <= 1'b0;
			dplus_resume_irq_enable_r <= 1'b0;
			usb_irq <= 1'b0;
		end else begin
			if (wr && a == REG_IRQ_EN)
				port2_cpu_irq_enable_r <= wd[0];
			if (wr && a == REG_P2_MSK)
				dplus_resume_irq_enable_r <= wd[0];
			if (wr && a == REG_P2_FLG && !wd[0])
				dplus_resume_flag_r <= 1'b0;
			if (dplus_resume_flag_set)
				dplus_resume_flag_r <= 1'b1;
			if (wr && a == REG_IRQ_FLG && !wd[0])
				port2_cpu_irq_flag_r <= 1'b0;
			if ((|hit) || (dplus_resume_flag_set && dplus_resume_irq_enable_r))
				port2_cpu_irq_flag_r <= 1'b1;
			usb_irq <= port2_cpu_irq_enable_r && port2_cpu_irq_flag_r;
		end
	end

	// endpoint 0 decode; only ep 0 is served here, others are left to the endpoint logic
	assign tok_me      = lnk_i.tok_v && usb_en_r && lnk_i.ep == 4'h0 && lnk_i.dev_addr == faddr_r;
	assign st_in_stat  = stat_r && stat_in_r;
	assign st_out_stat = stat_r && !stat_in_r;
	assign tx_data     = ep0_st_r == EP0_TX && !stat_r;
	assign rx_data     = ep0_st_r == EP0_RX && !stat_r;
	always_comb begin
		stall_cond = 1'b0;
		if (tok_me && lnk_i.tok != TOK_SETUP) begin
			if (send_stall_r)
				stall_cond = 1'b1;
			else if (lnk_i.tok == TOK_IN)
				stall_cond = !st_in_stat && !tx_data && data_end_r;
			else if (lnk_i.tok == TOK_OUT)
				stall_cond = (st_out_stat && lnk_i.len != 7'h00) || (rx_data && lnk_i.len > EP0_MAX_PKT)
					|| (!st_out_stat && !rx_data && data_end_r);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst || srst) begin
			ep0_st_r     <= EP0_IDLE;
			rx_wait_r    <= 1'b0;
			tx_load_r    <= 1'b0;
			sent_stall_r <= 1'b0;
			data_end_r   <= 1'b0;
			setup_end_r  <= 1'b0;
			send_stall_r <= 1'b0;
			stat_r       <= 1'b0;
			stat_in_r    <= 1'b0;
			has_data_r   <= 1'b0;
			dir_in_r     <= 1'b0;
			pend_data_r  <= 1'b0;
			pend_stat_r  <= 1'b0;
			cnt_r        <= 7'h00;
			ep0_evt_r    <= 1'b0;
			hs_v_r       <= 1'b0;
			hs_code_r    <= HS_ACK;
		end else begin
			hs_v_r    <= 1'b0;
			ep0_evt_r <= 1'b0;
			// host acknowledged the data we sent
			if (lnk_i.in_ack && pend_data_r) begin
				pend_data_r <= 1'b0;
				tx_load_r   <= 1'b0;
				ep0_evt_r   <= 1'b1;
				if (data_end_r) begin
					stat_r    <= 1'b1;
					stat_in_r <= 1'b0;
				end
			end
			if (lnk_i.in_ack && pend_stat_r) begin
				pend_stat_r <= 1'b0;
				ep0_evt_r   <= 1'b1;
				ep0_st_r    <= EP0_IDLE;
				stat_r      <= 1'b0;
				data_end_r  <= 1'b0;
			end
			// firmware writes to the status register
			if (cs_wr) begin
				if (!wd[B_SENT_STL])
					sent_stall_r <= 1'b0;
				if (wd[B_TX_LOAD])
					tx_load_r <= 1'b1;
				if (wd[B_DATA_END])
					data_end_r <= 1'b1;
				if (wd[B_SEND_STL])
					send_stall_r <= 1'b1;
				if (wd[B_EARLY_ACK])
					setup_end_r <= 1'b0;
				if (wd[B_RX_REL] && rx_wait_r) begin
					rx_wait_r <= 1'b0;
					if (ep0_st_r == EP0_IDLE) begin
						if (wd[B_DATA_END]) begin
							stat_r    <= 1'b1;
							stat_in_r <= 1'b1;
						end else if (has_data_r)
							ep0_st_r <= dir_in_r ? EP0_TX : EP0_RX;
					end else if (ep0_st_r == EP0_RX && wd[B_DATA_END]) begin
						stat_r    <= 1'b1;
						stat_in_r <= 1'b1;
					end
				end
			end
			// host tokens come last so hardware sets win over firmware clears
			if (stall_cond) begin
				hs_v_r       <= 1'b1;
				hs_code_r    <= HS_STALL;
				sent_stall_r <= 1'b1;
				send_stall_r <= 1'b0;
				ep0_evt_r    <= 1'b1;
				ep0_st_r     <= EP0_IDLE;
				stat_r       <= 1'b0;
				data_end_r   <= 1'b0;
				tx_load_r    <= 1'b0;
				pend_data_r  <= 1'b0;
				pend_stat_r  <= 1'b0;
			end else if (tok_me) begin
				case (lnk_i.tok)
					TOK_SETUP: begin
						// wrong length setups get no handshake at all
						if (lnk_i.len == SETUP_LEN) begin
							if (ep0_st_r != EP0_IDLE || stat_r)
								setup_end_r <= 1'b1;
							ep0_st_r    <= EP0_IDLE;
							stat_r      <= 1'b0;
							data_end_r  <= 1'b0;
							tx_load_r   <= 1'b0;
							pend_data_r <= 1'b0;
							pend_stat_r <= 1'b0;
							rx_wait_r   <= 1'b1;
							cnt_r       <= lnk_i.len;
							has_data_r  <= lnk_i.setup_has_data;
							dir_in_r    <= lnk_i.setup_dir_in;
							ep0_evt_r   <= 1'b1;
							hs_v_r      <= 1'b1;
							hs_code_r   <= HS_ACK;
						end
					end
					TOK_IN: begin
						hs_v_r <= 1'b1;
						if (st_in_stat) begin
							hs_code_r   <= HS_DATA; // zero-length status reply
							pend_stat_r <= 1'b1;
						end else if (tx_data && tx_load_r) begin
							hs_code_r   <= HS_DATA;
							pend_data_r <= 1'b1;
						end else if (ep0_st_r == EP0_RX) begin
							hs_v_r      <= 1'b0;
							setup_end_r <= 1'b1;
							ep0_evt_r   <= 1'b1;
							ep0_st_r    <= EP0_IDLE;
						end else
							hs_code_r <= HS_NAK;
					end
					TOK_OUT: begin
						hs_v_r <= 1'b1;
						if (st_out_stat) begin
							hs_code_r  <= HS_ACK;
							ep0_st_r   <= EP0_IDLE;
							stat_r     <= 1'b0;
							data_end_r <= 1'b0;
						end else if (rx_data && !rx_wait_r) begin
							hs_code_r <= HS_ACK;
							rx_wait_r <= 1'b1;
							cnt_r     <= lnk_i.len;
							ep0_evt_r <= 1'b1;
						end else if (rx_data)
							hs_code_r <= HS_NAK;
						else if (ep0_st_r == EP0_TX) begin
							hs_v_r      <= 1'b0;
							setup_end_r <= 1'b1;
							ep0_evt_r   <= 1'b1;
							ep0_st_r    <= EP0_IDLE;
						end else
							hs_code_r <= HS_NAK;
					end
					default: hs_v_r <= 1'b0;
				endcase
			end
		end
	end

	// register read mux, answered one cycle after the strobe
	always_comb begin
		rdata_nxt = 8'h00;
		case (a)
			REG_CTRL:    rdata_nxt = {lock_s_r, 4'h0, pll_en_r, pullup_r, usb_en_r};
			REG_PAD:     rdata_nxt = {7'h00, pad_pd_r};
			REG_FLG0:    rdata_nxt = flg_r[0];
			4'h3:        rdata_nxt = flg_r[1];
			4'h4:        rdata_nxt = flg_r[2];
			REG_MSK0:    rdata_nxt = msk_r[0];
			4'h6:        rdata_nxt = msk_r[1];
			4'h7:        rdata_nxt = msk_r[2];
			REG_FADDR:   rdata_nxt = {1'b0, faddr_r};
			REG_EPSEL:   rdata_nxt = {4'h0, epsel_r};
			REG_EP0_CS:  rdata_nxt = (epsel_r != 4'h0) ? 8'h00 : {2'b00, send_stall_r, setup_end_r,
				data_end_r, sent_stall_r, tx_load_r, rx_wait_r};
			REG_EP0_CNT: rdata_nxt = (epsel_r == 4'h0 && rx_wait_r) ? {1'b0, cnt_r} : 8'h00;
			REG_IRQ_EN:  rdata_nxt = {7'h00, port2_cpu_irq_enable_r};
			REG_IRQ_FLG: rdata_nxt = {7'h00, port2_cpu_irq_flag_r};
			REG_P2_FLG:  rdata_nxt = {7'h00, dplus_resume_flag_r};
			REG_P2_MSK:  rdata_nxt = {7'h00, dplus_resume_irq_enable_r};
			default:     rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			rdata_r <= 8'h00;
		else
			rdata_r <= rd ? rdata_nxt : 8'h00;
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	ctrl_hold_a: assert property (!usb_en_r |=> ep0_st_r == EP0_IDLE && !rx_wait_r && !tx_load_r && !send_stall_r)
		else $error("endpoint 0 state survived controller reset");
	pullup_src_a: assert property ($rose(lnk_o.pullup_on) |-> $past(wr && a == REG_CTRL && wd[B_PULLUP]))
		else $error("pullup turned on without a control write");
	lock_sync_a: assert property (##2 lock_s_r == $past(lnk_i.pll_lock, 2))
		else $error("pll lock status not two cycles behind");
	irq_gate_a: assert property ($rose(usb_irq) |-> $past(port2_cpu_irq_enable_r) && $past(port2_cpu_irq_flag_r))
		else $error("interrupt raised without enable and flag");
	flag_clear_a: assert property (rd && a == 4'h3 && !ep0_evt_r |=> flg_r[1] == 8'h00)
		else $error("in flags not cleared by read");
	flag_keep_a: assert property (ep0_evt_r && usb_en_r |=> flg_r[1][0])
		else $error("endpoint 0 event lost against a read");
	stall_reply_a: assert property (stall_cond |=> hs_v_r && hs_code_r == HS_STALL && sent_stall_r
		##1 (!hs_v_r || $past(tok_me)))
		else $error("stall reply or sent-stall missing");
	empty_nak_a: assert property (tok_me && lnk_i.tok == TOK_IN && tx_data && !tx_load_r && !stall_cond
		|=> hs_v_r && hs_code_r == HS_NAK)
		else $error("empty endpoint 0 did not nak");
	setup_len_a: assert property (tok_me && lnk_i.tok == TOK_SETUP && lnk_i.len != SETUP_LEN |=> !hs_v_r)
		else $error("wrong length setup answered");
	enter_tx_a: assert property (usb_en_r && cs_wr && wd[B_RX_REL] && !wd[B_DATA_END] && rx_wait_r
		&& ep0_st_r == EP0_IDLE && has_data_r && dir_in_r && !tok_me |=> ep0_st_r == EP0_TX)
		else $error("release did not enter tx");
	sent_evt_a: assert property (usb_en_r && lnk_i.in_ack && pend_data_r && !cs_wr |=> ep0_evt_r && !tx_load_r)
		else $error("sent packet did not clear loaded");
endmodule : ubc_core
`default_nettype wire

//--- rtl/ubc_pkg.sv
// ubc_pkg: register map, field positions, codes and carriers for the usb enable and control-endpoint block
`default_nettype none
package ubc_pkg;
	// register word addresses on the plain register port
	localparam logic [3:0] REG_CTRL    = 4'h0; // usb_control_reg
	localparam logic [3:0] REG_PAD     = 4'h1; // test_pad_reg
	localparam logic [3:0] REG_FLG0    = 4'h2; // common, in, out event flags at 2..4
	localparam logic [3:0] REG_MSK0    = 4'h5; // common, in, out event masks at 5..7
	localparam logic [3:0] REG_FADDR   = 4'h8; // function_address_reg
	localparam logic [3:0] REG_EPSEL   = 4'h9; // endpoint_select_reg
	localparam logic [3:0] REG_EP0_CS  = 4'ha; // ctrl_ep_status_reg
	localparam logic [3:0] REG_EP0_CNT = 4'hb; // ctrl_ep_rx_count
	localparam logic [3:0] REG_IRQ_EN  = 4'hc; // cpu_irq_enable_reg2
	localparam logic [3:0] REG_IRQ_FLG = 4'hd; // cpu_irq_flag_reg2
	localparam logic [3:0] REG_P2_FLG  = 4'he; // port2_pin_flags
	localparam logic [3:0] REG_P2_MSK  = 4'hf; // port2_pin_irq_mask
	// usb_control_reg fields
	localparam int B_USB_EN = 0;
	localparam int B_PULLUP = 1;
	localparam int B_PLL_EN = 2;
	localparam int B_LOCKED = 7;
	// ctrl_ep_status_reg fields
	localparam int B_RX_WAIT   = 0;
	localparam int B_TX_LOAD   = 1;
	localparam int B_SENT_STL  = 2;
	localparam int B_DATA_END  = 3;
	localparam int B_SETUP_END = 4;
	localparam int B_SEND_STL  = 5;
	localparam int B_RX_REL    = 6;
	localparam int B_EARLY_ACK = 7;
	// common_event_flags fields
	localparam int B_SUSPEND = 0;
	localparam int B_RESUME  = 1;
	localparam int B_BUS_RST = 2;
	localparam int B_SOF     = 3;
	// mask reset values: common has only resume and bus reset on, in has bits 0..5 on, out bits 1..5
	localparam logic [7:0] RST_CMSK = 8'h06;
	localparam logic [7:0] RST_IMSK = 8'h3f;
	localparam logic [7:0] RST_OMSK = 8'h3e;
	// endpoint 0 packet limits
	localparam logic [6:0] EP0_MAX_PKT = 7'h20;
	localparam logic [6:0] SETUP_LEN   = 7'h08;
	// token kinds from the serial engine
	localparam logic [1:0] TOK_SETUP = 2'h0;
	localparam logic [1:0] TOK_IN    = 2'h1;
	localparam logic [1:0] TOK_OUT   = 2'h2;
	// handshake / reply codes to the serial engine
	localparam logic [1:0] HS_ACK   = 2'h0;
	localparam logic [1:0] HS_NAK   = 2'h1;
	localparam logic [1:0] HS_STALL = 2'h2;
	localparam logic [1:0] HS_DATA  = 2'h3;

	typedef enum logic [2:0] {
		EP0_IDLE = 3'b001,
		EP0_TX   = 3'b010,
		EP0_RX   = 3'b100
	} ubc_ep0_st_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} ubc_bus_req_t;

	typedef struct packed {
		logic       tok_v;
		logic [1:0] tok;
		logic [6:0] dev_addr;
		logic [3:0] ep;
		logic [6:0] len;
		logic       setup_dir_in;
		logic       setup_has_data;
		logic       in_ack;
		logic       dplus;
		logic       suspended;
		logic       bus_reset;
		logic       sof;
		logic       pll_lock;
	} ubc_link_in_t;

	typedef struct packed {
		logic       hs_v;
		logic [1:0] hs_code;
		logic       pullup_on;
		logic       pad_power_down;
		logic       pll_en;
		logic       ctrl_reset;
		logic       addressed;
	} ubc_link_out_t;
endpackage : ubc_pkg
`default_nettype wire

//--- tb/ubc_host_model.sv
// ubc_host_model: usb host and pll stand-in driving the link side of the core
`default_nettype none
module ubc_host_model import ubc_pkg::*; (
	input  wire logic          ref_clk,
	input  wire ubc_link_out_t lnk_o,
	output ubc_link_in_t       lnk_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] lock_cnt_r;
	initial begin
		lnk_i = '0;
		lnk_i.dplus = 1'b1;
		lock_cnt_r = 4'h0;
	end
	// lock comes late and drops at once, so firmware has to poll the status bit
	always @(posedge ref_clk) begin
		lock_cnt_r <= lnk_o.pll_en ? lock_cnt_r + {3'h0, lock_cnt_r != 4'hf} : 4'h0;
		lnk_i.pll_lock <= lock_cnt_r == 4'hf;
	end
	// released token, address, endpoint and length fields flip so nothing can lean on a stale value
	task automatic token(input logic [1:0] tok, input logic [6:0] fa, input logic [6:0] len,
		input logic dir, input logic hd, output logic [7:0] hs);
		@(posedge ref_clk);
		lnk_i.tok_v <= 1'b1;
		lnk_i.tok <= tok;
		lnk_i.dev_addr <= fa;
		lnk_i.ep <= 4'h0;
		lnk_i.len <= len;
		lnk_i.setup_dir_in <= dir;
		lnk_i.setup_has_data <= hd;
		@(posedge ref_clk);
		lnk_i.tok_v <= 1'b0;
		lnk_i.tok <= ~tok;
		lnk_i.dev_addr <= ~fa;
		lnk_i.ep <= 4'hf;
		lnk_i.len <= ~len;
		#1;
		hs = {5'h0, lnk_o.hs_v, lnk_o.hs_v ? lnk_o.hs_code : 2'h0};
	endtask : token
	task automatic in_ack();
		@(posedge ref_clk);
		lnk_i.in_ack <= 1'b1;
		@(posedge ref_clk);
		lnk_i.in_ack <= 1'b0;
	endtask : in_ack
	task automatic resume();
		@(posedge ref_clk);
		lnk_i.suspended <= 1'b1;
		@(posedge ref_clk);
		lnk_i.dplus <= 1'b0;
		repeat (3) @(posedge ref_clk);
		lnk_i.dplus <= 1'b1;
		lnk_i.suspended <= 1'b0;
	endtask : resume
endmodule : ubc_host_model
`default_nettype wire

//--- tb/ubc_core_tb.sv
// ubc_core_tb: self-checking bench for enable, pads, pll, event flags and endpoint-0 transfers
`default_nettype none
module ubc_core_tb import ubc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] A_INF = REG_FLG0 + 4'h1;
	logic          ref_clk;
	logic          rst;
	ubc_bus_req_t  bus_i;
	logic [7:0]    bus_rdata;
	ubc_link_in_t  lnk_i;
	ubc_link_out_t lnk_o;
	logic          usb_irq;
	int            num_errors;
	int            samples_checked;
	logic [7:0]    v;
	logic [6:0]    n;
	logic [6:0]    fa;

	ubc_core dut_u (.ref_clk(ref_clk), .rst(rst), .bus_i(bus_i), .bus_rdata(bus_rdata),
		.lnk_i(lnk_i), .lnk_o(lnk_o), .usb_irq(usb_irq));
	ubc_host_model host_u (.ref_clk(ref_clk), .lnk_o(lnk_o), .lnk_i(lnk_i));

	initial ref_clk = 1'b0;
	always #12.5 ref_clk = ~ref_clk;

	function automatic logic [7:0] reply(input logic hv, input logic [1:0] c);
		return {5'h0, hv, c};
	endfunction : reply
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge ref_clk);
		bus_i.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge ref_clk);
		bus_i.rd <= 1'b0;
		#1;
		d = bus_rdata;
	endtask : rd
	task automatic rchk(input string what, input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk(what, d, exp);
	endtask : rchk
	task automatic tchk(input string what, input logic [1:0] tok, input logic [6:0] len,
		input logic dir, input logic hd, input logic [7:0] exp);
		logic [7:0] hs;
		host_u.token(tok, fa, len, dir, hd, hs);
		chk(what, hs, exp);
	endtask : tchk
	task automatic settle();
		repeat (2) @(posedge ref_clk);
		#1;
	endtask : settle
	task automatic close_out();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out

	// generous against the few hundred cycles the sequence needs
	initial begin
		repeat (5000) @(posedge ref_clk);
		num_errors++;
		close_out();
	end

	initial begin
		bus_i = '0;
		rst = 1'b1;
		fa = 7'h00;
		num_errors = 0;
		samples_checked = 0;
		void'($urandom(32'h64dd));
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		settle();
		chk("pins at reset", {3'h0, lnk_o[4:0]}, 8'h02);
		rchk("common mask", REG_MSK0, RST_CMSK);
		rchk("in mask", REG_MSK0 + 4'h1, RST_IMSK);
		rchk("out mask", REG_MSK0 + 4'h2, RST_OMSK);
		wr(REG_PAD, 8'h01);
		settle();
		chk("pad down", {3'h0, lnk_o[4:0]}, 8'h0a);
		wr(REG_PAD, 8'h00);
		wr(REG_CTRL, 8'h07);
		settle();
		chk("enabled pins", {3'h0, lnk_o[4:0]}, 8'h14);
		v = 8'h00;
		for (int i = 0; i < 40 && !v[B_LOCKED]; i++)
			rd(REG_CTRL, v);
		chk("pll locked", v, 8'h87);
		wr(REG_IRQ_EN, 8'h01);
		tchk("short setup", TOK_SETUP, 7'h07, 1'b1, 1'b1, reply(1'b0, 2'h0));
		tchk("setup in", TOK_SETUP, SETUP_LEN, 1'b1, 1'b1, reply(1'b1, HS_ACK));
		rchk("cpu flag", REG_IRQ_FLG, 8'h01);
		chk("irq up", {7'h0, usb_irq}, 8'h01);
		rchk("setup count", REG_EP0_CNT, {1'b0, SETUP_LEN});
		rchk("in flags", A_INF, 8'h01);
		rchk("in flags again", A_INF, 8'h00);
		wr(REG_IRQ_FLG, 8'h00);
		settle();
		chk("irq down", {7'h0, usb_irq}, 8'h00);
		wr(REG_EP0_CS, 8'h40);
		tchk("in empty", TOK_IN, 7'h00, 1'b0, 1'b0, reply(1'b1, HS_NAK));
		wr(REG_EP0_CS, 8'h02);
		tchk("in data", TOK_IN, 7'h00, 1'b0, 1'b0, reply(1'b1, HS_DATA));
		host_u.in_ack();
		rchk("loaded cleared", REG_EP0_CS, 8'h00);
		rchk("sent event", A_INF, 8'h01);
		wr(REG_EP0_CS, 8'h0a);
		tchk("last in", TOK_IN, 7'h00, 1'b0, 1'b0, reply(1'b1, HS_DATA));
		host_u.in_ack();
		tchk("out status", TOK_OUT, 7'h00, 1'b0, 1'b0, reply(1'b1, HS_ACK));
		tchk("idle in", TOK_IN, 7'h00, 1'b0, 1'b0, reply(1'b1, HS_NAK));
		// out data stage: two full packets, then one of random size
		tchk("setup out", TOK_SETUP, SETUP_LEN, 1'b0, 1'b1, reply(1'b1, HS_ACK));
		wr(REG_EP0_CS, 8'h40);
		for (int i = 0; i < 3; i++) begin
			// full packets first; only the closing one may be short
			n = (i == 2) ? 7'($urandom_range(31, 0)) : EP0_MAX_PKT;
			tchk("out data", TOK_OUT, n, 1'b0, 1'b0, reply(1'b1, HS_ACK));
			rchk("rx count", REG_EP0_CNT, {1'b0, n});
			wr(REG_EP0_CS, (i == 2) ? 8'h48 : 8'h40);
		end
		tchk("out after end", TOK_OUT, 7'h00, 1'b0, 1'b0, reply(1'b1, HS_STALL));
		rd(REG_EP0_CS, v);
		chk("stall bit", {7'h0, v[B_SENT_STL]}, 8'h01);
		wr(REG_EP0_CS, 8'h00);
		tchk("setup out", TOK_SETUP, SETUP_LEN, 1'b0, 1'b1, reply(1'b1, HS_ACK));
		wr(REG_EP0_CS, 8'h40);
		tchk("oversize", TOK_OUT, EP0_MAX_PKT + 7'h01, 1'b0, 1'b0, reply(1'b1, HS_STALL));
		rd(REG_EP0_CS, v);
		chk("oversize stall", {7'h0, v[B_SENT_STL]}, 8'h01);
		wr(REG_EP0_CS, 8'h00);
		tchk("setup in", TOK_SETUP, SETUP_LEN, 1'b1, 1'b1, reply(1'b1, HS_ACK));
		wr(REG_EP0_CS, 8'h40);
		tchk("wrong dir", TOK_OUT, 7'h00, 1'b0, 1'b0, reply(1'b0, 2'h0));
		rd(REG_EP0_CS, v);
		chk("setup end", {7'h0, v[B_SETUP_END]}, 8'h01);
		wr(REG_EP0_CS, 8'h80);
		rd(REG_EP0_CS, v);
		chk("setup end ack", {7'h0, v[B_SETUP_END]}, 8'h00);
		n = 7'($urandom_range(127, 1));
		wr(REG_FADDR, {1'b0, n});
		settle();
		chk("addressed", {7'h0, lnk_o.addressed}, 8'h01);
		tchk("old address", TOK_SETUP, SETUP_LEN, 1'b0, 1'b0, reply(1'b0, 2'h0));
		fa = n;
		tchk("new address", TOK_SETUP, SETUP_LEN, 1'b0, 1'b0, reply(1'b1, HS_ACK));
		wr(REG_EPSEL, 8'h01);
		rchk("other index", REG_EP0_CS, 8'h00);
		wr(REG_EPSEL, 8'h00);
		wr(REG_EP0_CS, 8'h68);
		tchk("forced stall", TOK_IN, 7'h00, 1'b0, 1'b0, reply(1'b1, HS_STALL));
		rd(REG_EP0_CS, v);
		chk("forced stall bit", {7'h0, v[B_SENT_STL]}, 8'h01);
		tchk("pending setup", TOK_SETUP, SETUP_LEN, 1'b1, 1'b1, reply(1'b1, HS_ACK));
		wr(REG_CTRL, 8'h06);
		settle();
		chk("held pins", {3'h0, lnk_o[4:0]}, 8'h16);
		wr(REG_CTRL, 8'h07);
		rchk("ep0 cleared", REG_EP0_CS, 8'h00);
		// pll goes off before the bus leaves active operation
		wr(REG_CTRL, 8'h03);
		settle();
		chk("pll off", {3'h0, lnk_o[4:0]}, 8'h10);
		host_u.resume();
		rchk("resume flag", REG_P2_FLG, 8'h01);
		rchk("common flags", REG_FLG0, 8'h03);
		close_out();
	end
endmodule : ubc_core_tb
`default_nettype wire
